// ### rtl/file_op_pkg.sv
package file_op_pkg;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_OR_ACCUM_FILE = 3'h0,
    OP_SHIFT_LEFT_FILE = 3'h1,
    OP_SHIFT_RIGHT_FILE = 3'h2,
    OP_COPY_FILE = 3'h3,
    OP_INDIRECT_LOAD = 3'h4
  } op_e;

  // ----------------------------------------------------------------
  // Pointer update codes
  // ----------------------------------------------------------------
  localparam logic [1:0] UPD_PRE_INC = 2'h0;
  localparam logic [1:0] UPD_PRE_DEC = 2'h1;
  localparam logic [1:0] UPD_POST_INC = 2'h2;
  localparam logic [1:0] UPD_POST_DEC = 2'h3;

  // ----------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FILE_AW = 7;
  localparam int PTR_W = 16;
  localparam int OFS_W = 6;
  localparam int NUM_PTR = 2;
  localparam logic [6:0] WINDOW0_FILE = 7'h00;
  localparam logic [6:0] WINDOW1_FILE = 7'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  localparam logic [15:0] PTR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ACCUM = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h01;
  localparam logic [7:0] REG_PTR0_LO = 8'h02;
  localparam logic [7:0] REG_PTR0_HI = 8'h03;
  localparam logic [7:0] REG_PTR1_LO = 8'h04;
  localparam logic [7:0] REG_PTR1_HI = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam int FLAG_NULL_BIT = 0;
  localparam int FLAG_SHOUT_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;

endpackage

// ### rtl/op_result_unit.sv
`timescale 1ns/10ps
`default_nettype none
module op_result_unit (
  input wire file_op_pkg::op_e op,
  input wire logic [7:0] accum,
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic shift_out,
  output logic shift_used
);
  import file_op_pkg::*;

  always_comb begin
    result = operand;
    shift_out = 1'b0;
    shift_used = 1'b0;
    case (op)
      OP_OR_ACCUM_FILE: begin
        result = accum | operand;
      end
      OP_SHIFT_LEFT_FILE: begin
        result = {operand[6:0], 1'b0};
        shift_out = operand[7];
        shift_used = 1'b1;
      end
      OP_SHIFT_RIGHT_FILE: begin
        result = {1'b0, operand[7:1]};
        shift_out = operand[0];
        shift_used = 1'b1;
      end
      default: begin
        result = operand;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/pointer_pair.sv
`timescale 1ns/10ps
`default_nettype none
module pointer_pair (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic bus_wr,
  input wire logic bus_idx,
  input wire logic bus_hi,
  input wire logic [7:0] bus_data,
  input wire logic upd_en,
  input wire logic upd_idx,
  input wire logic [15:0] upd_value,
  output logic [15:0] ptr0,
  output logic [15:0] ptr1
);
  import file_op_pkg::*;

  logic [15:0] ptr_r [NUM_PTR];

  // ----------------------------------------------------------------
  // One independent pointer per index
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
      // Instruction update wins over a software write in the same cycle
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ptr_r[gi] <= PTR_RESET;
        end else if (ce) begin
          if (upd_en && (upd_idx == 1'(gi))) begin
            ptr_r[gi] <= upd_value;
          end else if (bus_wr && (bus_idx == 1'(gi))) begin
            if (bus_hi) begin
              ptr_r[gi][15:8] <= bus_data;
            end else begin
              ptr_r[gi][7:0] <= bus_data;
            end
          end
        end
      end
    end
  endgenerate

  assign ptr0 = ptr_r[0];
  assign ptr1 = ptr_r[1];
endmodule
`default_nettype wire

// ### rtl/file_op_and_indirect_load_unit.sv
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module file_op_and_indirect_load_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic op_start,
  input wire file_op_pkg::op_e op_code,
  input wire logic [6:0] op_file_addr,
  input wire logic op_to_file,
  input wire logic op_ptr_idx,
  input wire logic [1:0] pointer_update_code,
  input wire logic op_relative,
  input wire logic [5:0] op_offset,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] accum,
  output logic null_flag,
  output logic shift_flag,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import file_op_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXEC = 2'b10
  } state_e;

  state_e state_r;
  op_e op_r;
  logic to_file_r;
  logic [15:0] mem_addr_r;
  logic mem_rd_r;
  logic mem_wr_r;
  logic [7:0] mem_wdata_r;
  logic busy_r;
  logic done_r;
  logic [7:0] accum_r;
  logic null_flag_r;
  logic shift_flag_r;
  logic [7:0] reg_rdata_r;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic [15:0] ptr_sel;
  logic [15:0] eff_addr_nxt;
  logic [15:0] ptr_upd_nxt;
  logic ptr_upd_en;
  logic use_window;
  logic win_idx;
  logic take;
  logic [7:0] result;
  logic shift_out;
  logic shift_used;

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  assign take = ce && op_start && (state_r == ST_IDLE);
  assign use_window = (op_code != OP_INDIRECT_LOAD) &&
    ((op_file_addr == WINDOW0_FILE) || (op_file_addr == WINDOW1_FILE));
  assign win_idx = (op_code == OP_INDIRECT_LOAD) ? op_ptr_idx :
    (op_file_addr == WINDOW1_FILE);
  assign ptr_sel = win_idx ? ptr1 : ptr0;

  always_comb begin
    eff_addr_nxt = {9'h000, op_file_addr};
    ptr_upd_nxt = ptr_sel;
    ptr_upd_en = 1'b0;
    if (use_window) begin
      eff_addr_nxt = ptr_sel;
    end else if (op_code == OP_INDIRECT_LOAD) begin
      if (op_relative) begin
        eff_addr_nxt = ptr_sel + {{10{op_offset[5]}}, op_offset};
      end else begin
        ptr_upd_en = take;
        case (pointer_update_code)
          UPD_PRE_INC: begin
            eff_addr_nxt = ptr_sel + PTR_ONE;
            ptr_upd_nxt = ptr_sel + PTR_ONE;
          end
          UPD_PRE_DEC: begin
            eff_addr_nxt = ptr_sel - PTR_ONE;
            ptr_upd_nxt = ptr_sel - PTR_ONE;
          end
          UPD_POST_INC: begin
            eff_addr_nxt = ptr_sel;
            ptr_upd_nxt = ptr_sel + PTR_ONE;
          end
          default: begin
            eff_addr_nxt = ptr_sel;
            ptr_upd_nxt = ptr_sel - PTR_ONE;
          end
        endcase
      end
    end
  end

  pointer_pair u_pointers (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .bus_wr(reg_wr && (reg_addr >= REG_PTR0_LO) &&
      (reg_addr <= REG_PTR1_HI)),
    .bus_idx(reg_addr[2]),
    .bus_hi(reg_addr[0]),
    .bus_data(reg_wdata),
    .upd_en(ptr_upd_en),
    .upd_idx(win_idx),
    .upd_value(ptr_upd_nxt),
    .ptr0(ptr0),
    .ptr1(ptr1)
  );

  op_result_unit u_result (
    .op(op_r),
    .accum(accum_r),
    .operand(mem_rdata),
    .result(result),
    .shift_out(shift_out),
    .shift_used(shift_used)
  );

  // ----------------------------------------------------------------
  // Sequencer: fetch, wait one cycle for data, execute
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      op_r <= OP_COPY_FILE;
      to_file_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r <= ST_WAIT;
            op_r <= op_code;
            to_file_r <= op_to_file && (op_code != OP_INDIRECT_LOAD);
            busy_r <= 1'b1;
          end
        end
        ST_WAIT: begin
          state_r <= ST_EXEC;
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_addr_r <= PTR_RESET;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_wdata_r <= BYTE_ZERO;
    end else if (ce) begin
      mem_rd_r <= take;
      mem_wr_r <= 1'b0;
      if (take) begin
        mem_addr_r <= eff_addr_nxt;
      end
      // Copy to itself rewrites the same byte, so the file stays intact
      if (state_r == ST_EXEC && to_file_r) begin
        mem_wr_r <= 1'b1;
        mem_wdata_r <= result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accum_r <= BYTE_ZERO;
      null_flag_r <= 1'b0;
      shift_flag_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_EXEC) begin
        if (!to_file_r) begin
          accum_r <= result;
        end
        null_flag_r <= (result == BYTE_ZERO);
        if (shift_used) begin
          shift_flag_r <= shift_out;
        end
      end else if (reg_wr && reg_addr == REG_ACCUM) begin
        accum_r <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_FLAGS) begin
        null_flag_r <= reg_wdata[FLAG_NULL_BIT];
        shift_flag_r <= reg_wdata[FLAG_SHOUT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_r <= BYTE_ZERO;
    end else if (ce) begin
      reg_rdata_r <= BYTE_ZERO;
      if (reg_rd) begin
        if (reg_addr == REG_ACCUM) begin
          reg_rdata_r <= accum_r;
        end else if (reg_addr == REG_FLAGS) begin
          reg_rdata_r <= {6'h00, shift_flag_r, null_flag_r};
        end else if (reg_addr == REG_PTR0_LO) begin
          reg_rdata_r <= ptr0[7:0];
        end else if (reg_addr == REG_PTR0_HI) begin
          reg_rdata_r <= ptr0[15:8];
        end else if (reg_addr == REG_PTR1_LO) begin
          reg_rdata_r <= ptr1[7:0];
        end else if (reg_addr == REG_PTR1_HI) begin
          reg_rdata_r <= ptr1[15:8];
        end else if (reg_addr == REG_STATUS) begin
          reg_rdata_r <= {7'h00, busy_r};
        end
      end
    end
  end

  assign mem_addr = mem_addr_r;
  assign mem_rd = mem_rd_r;
  assign mem_wr = mem_wr_r;
  assign mem_wdata = mem_wdata_r;
  assign busy = busy_r;
  assign done = done_r;
  assign accum = accum_r;
  assign null_flag = null_flag_r;
  assign shift_flag = shift_flag_r;
  assign reg_rdata = reg_rdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_exec;
    state_r == ST_EXEC;
  endsequence

  sequence s_load_start;
    take && op_code == OP_INDIRECT_LOAD && !op_relative;
  endsequence

  a_or_result: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s_exec and (op_r == OP_OR_ACCUM_FILE && !to_file_r) |=>
      accum_r == ($past(accum_r) | $past(mem_rdata)))
    else $error("OR result wrong");
  a_dest_file: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s_exec and to_file_r |=> mem_wr_r && mem_wdata_r == $past(result)
      && accum_r == $past(accum_r))
    else $error("Write-back target wrong");
  a_left_shift: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s_exec and op_r == OP_SHIFT_LEFT_FILE |=>
      shift_flag_r == $past(mem_rdata[7]) && $past(result[0]) == 1'b0)
    else $error("Left shift wrong");
  a_right_shift: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s_exec and op_r == OP_SHIFT_RIGHT_FILE |=>
      shift_flag_r == $past(mem_rdata[0]) && $past(result[7]) == 1'b0)
    else $error("Right shift wrong");
  a_null_flag: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s_exec |=> null_flag_r == ($past(result) == BYTE_ZERO))
    else $error("Null flag wrong");
  a_load_timing: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    take |=> mem_rd_r && busy_r ##1 busy_r ##1 done_r && !busy_r)
    else $error("Operation timing wrong");
  a_pre_inc_addr: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s_load_start and pointer_update_code == UPD_PRE_INC |=>
      mem_addr_r == $past(ptr_sel) + PTR_ONE)
    else $error("Pre-increment address wrong");
  a_post_dec_ptr: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    s_load_start and pointer_update_code == UPD_POST_DEC |=>
      mem_addr_r == $past(ptr_sel) &&
      (($past(op_ptr_idx) ? ptr1 : ptr0) == $past(ptr_sel) - PTR_ONE))
    else $error("Post-decrement pointer wrong");
  a_rel_keep: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    take && op_code == OP_INDIRECT_LOAD && op_relative |=>
      ptr0 == $past(ptr0) && ptr1 == $past(ptr1))
    else $error("Relative mode moved a pointer");
endmodule
`default_nettype wire

// ### sim/file_op_and_indirect_load_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); \
  end \
end
module file_op_and_indirect_load_unit_tb_top;
  import file_op_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic op_start = 1'b0;
  op_e op_code = OP_OR_ACCUM_FILE;
  logic [6:0] op_file_addr = 7'h00;
  logic op_to_file = 1'b0;
  logic op_ptr_idx = 1'b0;
  logic [1:0] pointer_update_code = 2'h0;
  logic op_relative = 1'b0;
  logic [5:0] op_offset = 6'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic [15:0] mem_addr;
  logic mem_rd, mem_wr, busy, done, null_flag, shift_flag;
  logic [7:0] mem_wdata, accum, reg_rdata;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] mem [0:65535];
  logic [7:0] acc_m;
  logic sh_m;
  int fail_count = 0;
  int n_compared = 0;

  always #2.5 clk = ~clk;

  file_op_and_indirect_load_unit uut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .op_start(op_start),
    .op_code(op_code), .op_file_addr(op_file_addr),
    .op_to_file(op_to_file), .op_ptr_idx(op_ptr_idx),
    .pointer_update_code(pointer_update_code),
    .op_relative(op_relative), .op_offset(op_offset),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .busy(busy), .done(done),
    .accum(accum), .null_flag(null_flag), .shift_flag(shift_flag),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // ----------------------------------------------------------------
  // Data memory seen by the unit
  // ----------------------------------------------------------------
  // Outside a read reply the data lines flip, so a late sample shows
  always @(posedge clk) begin
    if (mem_rd === 1'b1) begin
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic run(input op_e c, input logic [6:0] f, input logic tf,
                     input logic idx, input logic [1:0] upd,
                     input logic rel, input logic [5:0] ofs);
    int i;
    @(posedge clk);
    op_start <= 1'b1;
    op_code <= c;
    op_file_addr <= f;
    op_to_file <= tf;
    op_ptr_idx <= idx;
    pointer_update_code <= upd;
    op_relative <= rel;
    op_offset <= ofs;
    @(posedge clk);
    op_start <= 1'b0;
    #1;
    `CHK("busy", 1'b1, busy)
    `CHK("mem_rd", 1'b1, mem_rd)
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    if (i == 8) begin
      fail_count++;
      $display("unexpected done missing expected 1 seen 0");
    end
    `CHK("done cycle", 1, i)
    `CHK("busy end", 1'b0, busy)
  endtask

  // File operation with the expected result worked out here
  task automatic fop(input op_e c, input logic [6:0] f, input logic tf,
                     input logic [7:0] d);
    logic [7:0] res;
    res = d;
    case (c)
      OP_OR_ACCUM_FILE: res = acc_m | d;
      OP_SHIFT_LEFT_FILE: begin
        res = {d[6:0], 1'b0};
        sh_m = d[7];
      end
      OP_SHIFT_RIGHT_FILE: begin
        res = {1'b0, d[7:1]};
        sh_m = d[0];
      end
      default: res = d;
    endcase
    mem[{9'h000, f}] = d;
    run(c, f, tf, 1'b0, 2'h0, 1'b0, 6'h00);
    if (tf) begin
      `CHK("mem_wr", 1'b1, mem_wr)
      `CHK("mem_addr", {9'h000, f}, mem_addr)
      `CHK("mem_wdata", res, mem_wdata)
    end else begin
      acc_m = res;
    end
    `CHK("accum", acc_m, accum)
    `CHK("null_flag", res == 8'h00, null_flag)
    `CHK("shift_flag", sh_m, shift_flag)
  endtask

  task automatic ld(input logic idx, input logic [1:0] upd,
                    input logic rel, input logic [5:0] ofs,
                    input logic [15:0] p);
    logic [15:0] ea;
    logic [15:0] np;
    logic [7:0] base;
    base = idx ? REG_PTR1_LO : REG_PTR0_LO;
    reg_write(base, p[7:0]);
    reg_write(base + 8'h01, p[15:8]);
    np = p;
    if (rel) begin
      ea = p + {{10{ofs[5]}}, ofs};
    end else begin
      np = upd[0] ? p - PTR_ONE : p + PTR_ONE;
      ea = upd[1] ? p : np;
    end
    run(OP_INDIRECT_LOAD, 7'h00, 1'b0, idx, upd, rel, ofs);
    acc_m = mem[ea];
    `CHK("load accum", mem[ea], accum)
    `CHK("load null", mem[ea] == 8'h00, null_flag)
    reg_check(base, np[7:0]);
    reg_check(base + 8'h01, np[15:8]);
  endtask

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    $display("unexpected run length expected end seen hang");
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
    end
    mem[16'hffff] = 8'h00;
    acc_m = 8'h00;
    sh_m = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      reg_check(a[7:0], 8'h00);
    end
    reg_write(REG_ACCUM, 8'h5a);
    acc_m = 8'h5a;
    reg_check(REG_ACCUM, 8'h5a);
    fop(OP_OR_ACCUM_FILE, 7'h10, 1'b0, 8'h81);
    fop(OP_SHIFT_LEFT_FILE, 7'h20, 1'b0, 8'h81);
    fop(OP_OR_ACCUM_FILE, 7'h11, 1'b1, 8'h00);
    fop(OP_SHIFT_LEFT_FILE, 7'h21, 1'b1, 8'h80);
    fop(OP_SHIFT_RIGHT_FILE, 7'h22, 1'b0, 8'hfe);
    fop(OP_SHIFT_RIGHT_FILE, 7'h23, 1'b1, 8'h01);
    fop(OP_COPY_FILE, 7'h7f, 1'b0, 8'h33);
    fop(OP_COPY_FILE, 7'h30, 1'b1, 8'h00);
    fop(OP_COPY_FILE, 7'h31, 1'b1, 8'h9c);
    fop(OP_COPY_FILE, 7'h32, 1'b0, 8'h00);
    ld(1'b0, UPD_PRE_INC, 1'b0, 6'h00, 16'hffff);
    ld(1'b1, UPD_PRE_DEC, 1'b0, 6'h00, 16'h0000);
    ld(1'b0, UPD_POST_INC, 1'b0, 6'h00, 16'h1234);
    ld(1'b1, UPD_POST_DEC, 1'b0, 6'h00, 16'h8000);
    ld(1'b0, UPD_POST_INC, 1'b1, 6'h20, 16'h1000);
    ld(1'b1, UPD_PRE_DEC, 1'b1, 6'h1f, 16'h2000);
    // Window 0 reads through the pointer and leaves it alone
    reg_write(REG_PTR0_LO, 8'h21);
    reg_write(REG_PTR0_HI, 8'h43);
    mem[16'h4321] = 8'h00;
    run(OP_COPY_FILE, WINDOW0_FILE, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
    `CHK("window accum", 8'h00, accum)
    `CHK("window null", 1'b1, null_flag)
    reg_check(REG_PTR0_LO, 8'h21);
    reg_check(REG_PTR0_HI, 8'h43);
    // Window 1 follows pointer 1, still at its relative-mode value
    mem[16'h2000] = 8'h6b;
    run(OP_COPY_FILE, WINDOW1_FILE, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
    acc_m = 8'h6b;
    `CHK("window1 accum", acc_m, accum)
    reg_check(REG_FLAGS, {6'h00, sh_m, 1'b0});
    // Clock enable low must freeze the accumulator against a write
    @(posedge clk);
    ce <= 1'b0;
    reg_write(REG_ACCUM, 8'hff);
    ce <= 1'b1;
    reg_check(REG_ACCUM, acc_m);
    summarize();
  end
endmodule
`default_nettype wire
